// *** dcbd_decoder.sv ***
// Command block decoder: gathers the six-byte command block and the optional
// eight parameter bytes from the host byte stream and issues one decoded
// operation, or an invalid-command status, to the drive sequencer.
// Assumes host bytes arrive on mclk as a valid/ready stream from logic in the
// same clock domain, and that the sequencer accepts issue with cmd_ready.
//
// What this block does
// - Opcode 00 class 0 tests drive ready; only drive bit used.
// - Opcode 01 recalibrates the drive using retry bit and step code.
// - Opcode 03 returns sense status for the selected drive.
// - Opcode 04 formats the drive from head and cylinder with interleave.
// - Opcode 05 verifies sectors using block count, retry, reread, step.
// - Opcode 06 formats one track with the five-bit interleave.
// - Opcode 07 formats a bad track with the same fields.
// - Opcode 08 reads sectors; byte 2 holds cylinder high and sector.
// - Class 0 codes 02, 09 and class 7 codes 01, 02 are unused.
// - Opcode 0A writes counted sectors with retry bit and step code.
// - Opcode 0B seeks cylinder and head, ignoring byte 4.
// - Opcode 0C takes eight further bytes as drive characteristics.
// - Parameter byte order: cylinders, heads, reduced current, precomp, burst.
// - Opcode 0D returns the last ECC burst error length.
// - Opcodes 0E and 0F move sector buffer data out and in.
// - Class 7 opcode 00 runs the sector buffer memory diagnostic.
// - Class 7 opcode 03 diagnoses the drive with retry and step.
// - Class 7 opcode 04 runs controller self-tests without a drive.
// - Class 7 opcodes 05, 06 are long read and long write.
// - Drive is one bit; don't-care fields are never checked.
// - Class is byte 0 bits 7 to 5, opcode bits 4 to 0.
// - Control bit 7 suppresses four retries; bit 6 clear allows reread.
// - Long read delivers 512 data plus 4 ECC bytes per sector.
module dcbd_decoder (
  input  wire logic                 mclk,
  input  wire logic                 rst_b,
  input  wire logic [7:0]           host_byte,
  input  wire logic                 host_valid,
  output logic                      host_ready,
  output dcbd_pkg::dcbd_cmd_s       cmd,
  output logic                      cmd_valid,
  input  wire logic                 cmd_ready,
  output logic                      invalid_cmd,
  output logic [5:0]                err_code,
  output dcbd_pkg::dcbd_char_s      drive_char,
  output logic                      char_valid
);

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Maps class and opcode to an operation; unused codes map to none.
  function automatic dcbd_pkg::dcbd_op_e decode_op(input logic [7:0] b0);
    logic [2:0] cls;
    logic [4:0] opc;
    dcbd_pkg::dcbd_op_e r;
    cls = b0[dcbd_pkg::CLASS_MSB:dcbd_pkg::CLASS_LSB];
    opc = b0[dcbd_pkg::CLASS_LSB-1:0];
    r   = dcbd_pkg::DCBD_OP_NONE;
    if (cls == dcbd_pkg::CLASS_DATA) begin
      case (opc)
        dcbd_pkg::OP_TEST_READY: r = dcbd_pkg::DCBD_OP_TEST;
        dcbd_pkg::OP_RECAL:      r = dcbd_pkg::DCBD_OP_RECAL;
        dcbd_pkg::OP_SENSE:      r = dcbd_pkg::DCBD_OP_SENSE;
        dcbd_pkg::OP_FMT_DRIVE:  r = dcbd_pkg::DCBD_OP_FMT_DRIVE;
        dcbd_pkg::OP_VERIFY:     r = dcbd_pkg::DCBD_OP_VERIFY;
        dcbd_pkg::OP_FMT_TRACK:  r = dcbd_pkg::DCBD_OP_FMT_TRACK;
        dcbd_pkg::OP_FMT_BAD:    r = dcbd_pkg::DCBD_OP_FMT_BAD;
        dcbd_pkg::OP_READ:       r = dcbd_pkg::DCBD_OP_READ;
        dcbd_pkg::OP_WRITE:      r = dcbd_pkg::DCBD_OP_WRITE;
        dcbd_pkg::OP_SEEK:       r = dcbd_pkg::DCBD_OP_SEEK;
        dcbd_pkg::OP_INIT_CHAR:  r = dcbd_pkg::DCBD_OP_INIT_CHAR;
        dcbd_pkg::OP_ECC_LEN:    r = dcbd_pkg::DCBD_OP_ECC_LEN;
        dcbd_pkg::OP_BUF_RD:     r = dcbd_pkg::DCBD_OP_BUF_RD;
        dcbd_pkg::OP_BUF_WR:     r = dcbd_pkg::DCBD_OP_BUF_WR;
        default:                 r = dcbd_pkg::DCBD_OP_NONE;
      endcase
    end else if (cls == dcbd_pkg::CLASS_DIAG) begin
      case (opc)
        dcbd_pkg::OP_RAM_DIAG:   r = dcbd_pkg::DCBD_OP_RAM_DIAG;
        dcbd_pkg::OP_DRV_DIAG:   r = dcbd_pkg::DCBD_OP_DRV_DIAG;
        dcbd_pkg::OP_CTL_DIAG:   r = dcbd_pkg::DCBD_OP_CTL_DIAG;
        dcbd_pkg::OP_RD_LONG:    r = dcbd_pkg::DCBD_OP_RD_LONG;
        dcbd_pkg::OP_WR_LONG:    r = dcbd_pkg::DCBD_OP_WR_LONG;
        default:                 r = dcbd_pkg::DCBD_OP_NONE;
      endcase
    end
    return r;
  endfunction

  // True for codes with no defined operation; these end with an error status.
  function automatic logic is_unused(input dcbd_pkg::dcbd_op_e op);
    return (op == dcbd_pkg::DCBD_OP_NONE);
  endfunction

  // Long transfers carry the check bytes along with every sector.
  function automatic logic is_long(input dcbd_pkg::dcbd_op_e op);
    return (op == dcbd_pkg::DCBD_OP_RD_LONG) || (op == dcbd_pkg::DCBD_OP_WR_LONG);
  endfunction

  // ==========================================================================
  // Byte gathering
  // ==========================================================================
  dcbd_pkg::dcbd_state_e state_r;
  dcbd_pkg::dcbd_state_e state_nxt;
  logic [7:0]            blk_r [dcbd_pkg::BLOCK_LEN];
  logic [7:0]            par_r [dcbd_pkg::PARAM_LEN];
  logic [3:0]            idx_r;
  logic                  take;
  logic                  last_blk;
  logic                  last_par;
  dcbd_pkg::dcbd_op_e    op_now;
  logic [7:0]            ctl_byte;

  assign take     = host_valid && host_ready;
  assign last_blk = (idx_r == 4'(dcbd_pkg::BLOCK_LEN - 1));
  assign last_par = (idx_r == 4'(dcbd_pkg::PARAM_LEN - 1));
  // The op is decoded from the stored first byte; the final block byte never
  // changes it, so decoding on the last take is safe.
  assign op_now   = decode_op(blk_r[0]);

  // The control byte is issued on the edge that takes it, one edge before
  // blk_r holds it, so at that edge it is read straight from the host.
  assign ctl_byte = (state_r == dcbd_pkg::DCBD_ST_BLOCK && last_blk && take) ? host_byte : blk_r[5];

  // Bytes are refused while an operation waits for the sequencer.
  assign host_ready = (state_r != dcbd_pkg::DCBD_ST_ISSUE);
  assign cmd_valid  = (state_r == dcbd_pkg::DCBD_ST_ISSUE);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      dcbd_pkg::DCBD_ST_BLOCK: begin
        if (take && last_blk) begin
          if (op_now == dcbd_pkg::DCBD_OP_INIT_CHAR) begin
            state_nxt = dcbd_pkg::DCBD_ST_PARAM;
          end else begin
            state_nxt = dcbd_pkg::DCBD_ST_ISSUE;
          end
        end
      end
      dcbd_pkg::DCBD_ST_PARAM: begin
        if (take && last_par) begin
          state_nxt = dcbd_pkg::DCBD_ST_ISSUE;
        end
      end
      dcbd_pkg::DCBD_ST_ISSUE: begin
        if (cmd_ready) begin
          state_nxt = dcbd_pkg::DCBD_ST_BLOCK;
        end
      end
      default: state_nxt = dcbd_pkg::DCBD_ST_BLOCK;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= dcbd_pkg::DCBD_ST_BLOCK;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      idx_r <= 4'h0;
    end else if (take) begin
      if ((state_r == dcbd_pkg::DCBD_ST_BLOCK && last_blk) ||
          (state_r == dcbd_pkg::DCBD_ST_PARAM && last_par)) begin
        idx_r <= 4'h0;
      end else begin
        idx_r <= idx_r + 4'h1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < dcbd_pkg::BLOCK_LEN; i++) begin
        blk_r[i] <= 8'h00;
      end
    end else if (take && state_r == dcbd_pkg::DCBD_ST_BLOCK) begin
      blk_r[idx_r[2:0]] <= host_byte;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < dcbd_pkg::PARAM_LEN; i++) begin
        par_r[i] <= 8'h00;
      end
    end else if (take && state_r == dcbd_pkg::DCBD_ST_PARAM) begin
      par_r[idx_r[2:0]] <= host_byte;
    end
  end

  // ==========================================================================
  // Field extraction
  // ==========================================================================
  // Fields the operation does not use are zeroed, or set for no_reread, rather than
  // checked, so any value the host left in them is accepted and never reaches cmd.
  dcbd_pkg::dcbd_cmd_s   fld;
  logic                  use_drive;
  logic                  use_addr;
  logic                  use_sector;
  logic                  use_count;
  logic                  use_ilv;
  logic                  use_ctl;

  always_comb begin
    use_drive  = 1'b0;
    use_addr   = 1'b0;
    use_sector = 1'b0;
    use_count  = 1'b0;
    use_ilv    = 1'b0;
    use_ctl    = 1'b0;
    case (op_now)
      dcbd_pkg::DCBD_OP_TEST, dcbd_pkg::DCBD_OP_SENSE: begin
        use_drive = 1'b1;
      end
      dcbd_pkg::DCBD_OP_RECAL, dcbd_pkg::DCBD_OP_DRV_DIAG: begin
        use_drive = 1'b1;
        use_ctl   = 1'b1;
      end
      dcbd_pkg::DCBD_OP_FMT_DRIVE, dcbd_pkg::DCBD_OP_FMT_TRACK,
      dcbd_pkg::DCBD_OP_FMT_BAD: begin
        use_drive = 1'b1;
        use_addr  = 1'b1;
        use_ilv   = 1'b1;
        use_ctl   = 1'b1;
      end
      dcbd_pkg::DCBD_OP_SEEK: begin
        use_drive = 1'b1;
        use_addr  = 1'b1;
        use_ctl   = 1'b1;
      end
      dcbd_pkg::DCBD_OP_VERIFY, dcbd_pkg::DCBD_OP_READ, dcbd_pkg::DCBD_OP_WRITE,
      dcbd_pkg::DCBD_OP_RD_LONG, dcbd_pkg::DCBD_OP_WR_LONG: begin
        use_drive  = 1'b1;
        use_addr   = 1'b1;
        use_sector = (op_now != dcbd_pkg::DCBD_OP_VERIFY);
        use_count  = 1'b1;
        use_ctl    = 1'b1;
      end
      default: begin
        use_drive = 1'b0;
      end
    endcase
  end

  always_comb begin
    fld    = '0;
    fld.op = op_now;
    if (use_drive) begin
      fld.drive = blk_r[1][dcbd_pkg::DRIVE_BIT];
    end
    if (use_addr) begin
      fld.head     = blk_r[1][4:0];
      fld.cylinder = {blk_r[2][7:6], blk_r[3]};
    end
    if (use_sector) begin
      fld.sector = blk_r[2][5:0];
    end
    if (use_count) begin
      fld.count      = blk_r[4];
      fld.data_bytes = dcbd_pkg::SECTOR_BYTES;
    end
    // Interleave range is the host's duty; it is passed through unchecked.
    if (use_ilv) begin
      fld.interleave = blk_r[4][4:0];
    end
    // Retries are dropped only on request.
    if (use_ctl) begin
      fld.no_retry = ctl_byte[dcbd_pkg::CTL_RETRY_BIT];
      fld.step     = ctl_byte[2:0];
      fld.retries  = ctl_byte[dcbd_pkg::CTL_RETRY_BIT] ? 3'h0 : dcbd_pkg::AUTO_RETRIES;
    end
    // Reread option applies to read and verify only; long read leaves no_reread set.
    fld.no_reread = 1'b1;
    if (op_now == dcbd_pkg::DCBD_OP_READ || op_now == dcbd_pkg::DCBD_OP_VERIFY) begin
      fld.no_reread = ctl_byte[dcbd_pkg::CTL_REREAD_BIT];
    end
    if (is_long(op_now)) begin
      fld.data_bytes = dcbd_pkg::SECTOR_BYTES;
      fld.ecc_bytes  = dcbd_pkg::ECC_BYTES;
    end
  end

  // ==========================================================================
  // Issue outputs
  // ==========================================================================
  logic entering_issue;
  assign entering_issue = (state_nxt == dcbd_pkg::DCBD_ST_ISSUE) &&
                          (state_r != dcbd_pkg::DCBD_ST_ISSUE);

  // Captured once, on entry, so the word stands while the sequencer stalls.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cmd <= '0;
    end else if (entering_issue) begin
      cmd <= fld;
    end
  end

  // An unused code still issues, with op none, so the sequencer can end the
  // command with the error status instead of dropping it silently.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      invalid_cmd <= 1'b0;
      err_code    <= 6'h00;
    end else if (entering_issue) begin
      invalid_cmd <= is_unused(op_now);
      err_code    <= is_unused(op_now) ? dcbd_pkg::ERR_INVALID : 6'h00;
    end
  end

  // ==========================================================================
  // Drive characteristics
  // ==========================================================================
  // Characteristics are kept across commands; the parameter bytes only
  // become visible once all eight have arrived.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      drive_char <= '0;
      char_valid <= 1'b0;
    end else if (take && state_r == dcbd_pkg::DCBD_ST_PARAM && last_par) begin
      drive_char.max_cyl       <= {par_r[0], par_r[1]};
      drive_char.max_heads     <= par_r[2];
      drive_char.rwc_cyl       <= {par_r[3], par_r[4]};
      drive_char.precomp_cyl   <= {par_r[5], par_r[6]};
      drive_char.max_ecc_burst <= host_byte;
      char_valid               <= 1'b1;
    end
  end

endmodule

// *** dcbd_pkg.sv ***
// Shared constants and types for the command block decoder.
// Assumes a single clock domain; everything here is elaboration-time only.
package dcbd_pkg;

  // ==========================================================================
  // Command block layout
  // ==========================================================================
  localparam int          BLOCK_LEN     = 6;
  localparam int          PARAM_LEN     = 8;
  localparam logic [2:0]  CLASS_DATA    = 3'h0;
  localparam logic [2:0]  CLASS_DIAG    = 3'h7;
  localparam int          CLASS_MSB     = 7;
  localparam int          CLASS_LSB     = 5;
  localparam int          DRIVE_BIT     = 5;
  localparam int          CTL_RETRY_BIT = 7;
  localparam int          CTL_REREAD_BIT = 6;
  localparam logic [2:0]  AUTO_RETRIES  = 3'h4;

  // ==========================================================================
  // Operation codes
  // ==========================================================================
  localparam logic [4:0] OP_TEST_READY = 5'h00;
  localparam logic [4:0] OP_RECAL      = 5'h01;
  localparam logic [4:0] OP_SENSE      = 5'h03;
  localparam logic [4:0] OP_FMT_DRIVE  = 5'h04;
  localparam logic [4:0] OP_VERIFY     = 5'h05;
  localparam logic [4:0] OP_FMT_TRACK  = 5'h06;
  localparam logic [4:0] OP_FMT_BAD    = 5'h07;
  localparam logic [4:0] OP_READ       = 5'h08;
  localparam logic [4:0] OP_WRITE      = 5'h0a;
  localparam logic [4:0] OP_SEEK       = 5'h0b;
  localparam logic [4:0] OP_INIT_CHAR  = 5'h0c;
  localparam logic [4:0] OP_ECC_LEN    = 5'h0d;
  localparam logic [4:0] OP_BUF_RD     = 5'h0e;
  localparam logic [4:0] OP_BUF_WR     = 5'h0f;
  localparam logic [4:0] OP_RAM_DIAG   = 5'h00;
  localparam logic [4:0] OP_DRV_DIAG   = 5'h03;
  localparam logic [4:0] OP_CTL_DIAG   = 5'h04;
  localparam logic [4:0] OP_RD_LONG    = 5'h05;
  localparam logic [4:0] OP_WR_LONG    = 5'h06;

  // ==========================================================================
  // Sector sizes and error status
  // ==========================================================================
  localparam logic [9:0]  SECTOR_BYTES   = 10'h200;
  localparam logic [2:0]  ECC_BYTES      = 3'h4;
  localparam logic [5:0]  ERR_INVALID    = 6'h20;

  typedef enum logic [19:0] {
    DCBD_OP_NONE      = 20'h00001,
    DCBD_OP_TEST      = 20'h00002,
    DCBD_OP_RECAL     = 20'h00004,
    DCBD_OP_SENSE     = 20'h00008,
    DCBD_OP_FMT_DRIVE = 20'h00010,
    DCBD_OP_VERIFY    = 20'h00020,
    DCBD_OP_FMT_TRACK = 20'h00040,
    DCBD_OP_FMT_BAD   = 20'h00080,
    DCBD_OP_READ      = 20'h00100,
    DCBD_OP_WRITE     = 20'h00200,
    DCBD_OP_SEEK      = 20'h00400,
    DCBD_OP_INIT_CHAR = 20'h00800,
    DCBD_OP_ECC_LEN   = 20'h01000,
    DCBD_OP_BUF_RD    = 20'h02000,
    DCBD_OP_BUF_WR    = 20'h04000,
    DCBD_OP_RAM_DIAG  = 20'h08000,
    DCBD_OP_DRV_DIAG  = 20'h10000,
    DCBD_OP_CTL_DIAG  = 20'h20000,
    DCBD_OP_RD_LONG   = 20'h40000,
    DCBD_OP_WR_LONG   = 20'h80000
  } dcbd_op_e;

  typedef enum logic [2:0] {
    DCBD_ST_BLOCK = 3'h1,
    DCBD_ST_PARAM = 3'h2,
    DCBD_ST_ISSUE = 3'h4
  } dcbd_state_e;

  // Decoded operation handed to the drive sequencer.
  typedef struct packed {
    dcbd_op_e    op;
    logic        drive;
    logic [4:0]  head;
    logic [9:0]  cylinder;
    logic [5:0]  sector;
    logic [7:0]  count;
    logic [4:0]  interleave;
    logic        no_retry;
    logic        no_reread;
    logic [2:0]  step;
    logic [2:0]  retries;
    logic [9:0]  data_bytes;
    logic [2:0]  ecc_bytes;
  } dcbd_cmd_s;

  // Drive characteristics gathered after the initialize command.
  typedef struct packed {
    logic [15:0] max_cyl;
    logic [7:0]  max_heads;
    logic [15:0] rwc_cyl;
    logic [15:0] precomp_cyl;
    logic [7:0]  max_ecc_burst;
  } dcbd_char_s;

endpackage

// *** dcbd_decoder_asserts.sv ***
// Concurrent checks on the ports of the command block decoder.
// Assumes one clock, mclk, and the asynchronous active-low reset rst_b.
module dcbd_decoder_asserts (
  input wire logic                 mclk,
  input wire logic                 rst_b,
  input wire logic [7:0]           host_byte,
  input wire logic                 host_valid,
  input wire logic                 host_ready,
  input wire dcbd_pkg::dcbd_cmd_s  cmd,
  input wire logic                 cmd_valid,
  input wire logic                 cmd_ready,
  input wire logic                 invalid_cmd,
  input wire logic [5:0]           err_code,
  input wire dcbd_pkg::dcbd_char_s drive_char,
  input wire logic                 char_valid
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] cnt_r;
  logic [7:0] b0_r;
  logic [7:0] b2_r;
  logic [7:0] b3_r;

  default clocking dc @(posedge mclk); endclocking
  default disable iff (!rst_b);

  // ==========================================================================
  // Byte tracking
  // ==========================================================================
  // Bytes taken since the last issue, so framing can be tied to the issue edge.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 4'h0;
    end else if (cmd_valid && cmd_ready) begin
      cnt_r <= 4'h0;
    end else if (host_valid && host_ready) begin
      cnt_r <= cnt_r + 4'h1;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      b0_r <= 8'h00;
      b2_r <= 8'h00;
      b3_r <= 8'h00;
    end else if (host_valid && host_ready) begin
      case (cnt_r)
        4'h0: b0_r <= host_byte;
        4'h2: b2_r <= host_byte;
        4'h3: b3_r <= host_byte;
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // Properties
  // ==========================================================================
  property p_refuse;
    cmd_valid |-> !host_ready;
  endproperty
  a_refuse: assert property (p_refuse) else $error("byte accepted while an operation waits");

  property p_hold;
    cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd) && $stable(invalid_cmd);
  endproperty
  a_hold: assert property (p_hold) else $error("waiting operation changed");

  property p_release;
    cmd_valid && cmd_ready |=> !cmd_valid [*2];
  endproperty
  a_release: assert property (p_release) else $error("operation not retired");

  property p_frame;
    $rose(cmd_valid) |-> cnt_r == 4'h6 || cnt_r == 4'he;
  endproperty
  a_frame: assert property (p_frame) else $error("issue after wrong byte count");

  property p_char_frame;
    $rose(cmd_valid) && cmd.op == dcbd_pkg::DCBD_OP_INIT_CHAR |-> cnt_r == 4'he;
  endproperty
  a_char_frame: assert property (p_char_frame) else $error("characteristics issued early");

  property p_invalid;
    cmd_valid && invalid_cmd |-> err_code == dcbd_pkg::ERR_INVALID && cmd.op == dcbd_pkg::DCBD_OP_NONE;
  endproperty
  a_invalid: assert property (p_invalid) else $error("invalid command status wrong");

  property p_class;
    $rose(cmd_valid) && b0_r[7:5] != dcbd_pkg::CLASS_DATA && b0_r[7:5] != dcbd_pkg::CLASS_DIAG |-> invalid_cmd;
  endproperty
  a_class: assert property (p_class) else $error("unknown class accepted");

  property p_unused;
    $rose(cmd_valid) && (b0_r == 8'h02 || b0_r == 8'h09 || b0_r == 8'he1 || b0_r == 8'he2) |-> invalid_cmd;
  endproperty
  a_unused: assert property (p_unused) else $error("unused opcode accepted");

  property p_cyl;
    $rose(cmd_valid) && cmd.op == dcbd_pkg::DCBD_OP_READ |-> cmd.cylinder == {b2_r[7:6], b3_r};
  endproperty
  a_cyl: assert property (p_cyl) else $error("cylinder assembled wrongly");

  property p_long;
    cmd_valid && cmd.op == dcbd_pkg::DCBD_OP_RD_LONG |-> cmd.ecc_bytes == dcbd_pkg::ECC_BYTES
      && cmd.data_bytes == dcbd_pkg::SECTOR_BYTES;
  endproperty
  a_long: assert property (p_long) else $error("long read sizes wrong");

  c_invalid: cover property ($rose(cmd_valid) && invalid_cmd);
  c_char: cover property ($rose(char_valid));
  c_stall: cover property (cmd_valid && host_valid);
endmodule

bind dcbd_decoder dcbd_decoder_asserts dcbd_decoder_asserts_i (
  .mclk(mclk), .rst_b(rst_b), .host_byte(host_byte), .host_valid(host_valid), .host_ready(host_ready),
  .cmd(cmd), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .invalid_cmd(invalid_cmd),
  .err_code(err_code), .drive_char(drive_char), .char_valid(char_valid));

// *** dcbd_host_model.sv ***
// Host model: offers command and parameter bytes on the decoder's byte stream.
// Assumes tasks are entered just after a rising edge of mclk.
module dcbd_host_model (
  input  wire logic mclk,
  input  wire logic host_ready,
  output logic [7:0] host_byte,
  output logic       host_valid,
  output logic       hang
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    host_byte = 8'h00;
    host_valid = 1'b0;
    hang = 1'b0;
  end

  // host_ready is sampled at the falling edge, where it has settled, so the
  // taking edge is never decided by process order.
  task automatic send(input logic [7:0] b);
    logic rdy;
    int   n;
    host_byte <= b;
    host_valid <= 1'b1;
    rdy = 1'b0;
    for (n = 0; n < 50 && !rdy; n++) begin
      @(negedge mclk);
      rdy = host_ready;
      @(posedge mclk);
    end
    if (!rdy) begin
      hang <= 1'b1;
    end
  endtask

  // High byte of each pair first, in the documented field order.
  task automatic send_char(input dcbd_pkg::dcbd_char_s c);
    int i;
    for (i = 7; i >= 0; i--) begin
      send(c[i*8 +: 8]);
    end
  endtask

  // A released line shows the inverse of its last value, so a stale byte is never taken for fresh.
  task automatic idle();
    host_valid <= 1'b0;
    host_byte <= ~host_byte;
  endtask
endmodule

// *** testbench.sv ***
// Self-checking bench for the command block decoder.
// Assumes the host model and the bound checker are compiled alongside.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  localparam dcbd_pkg::dcbd_char_s CHR = {16'h0132, 8'h04, 16'h0080, 16'h0100, 8'h0b};

  logic                 mclk, rst_b, cmd_ready, hang;
  logic                 host_valid, host_ready, cmd_valid, invalid_cmd, char_valid;
  logic [7:0]           host_byte;
  logic [5:0]           err_code;
  dcbd_pkg::dcbd_cmd_s  cmd;
  dcbd_pkg::dcbd_char_s drive_char;
  int                   err_count = 0;
  int                   total_checks = 0;
  int                   i;
  logic [7:0]           good_ops [19] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0a,
                          8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'he0, 8'he3, 8'he4, 8'he5, 8'he6};
  logic [7:0]           bad_ops [6] = '{8'h02, 8'h09, 8'he1, 8'he2, 8'h10, 8'h3f};

  initial mclk = 1'b0;
  always #2.5 mclk = ~mclk;

  dcbd_decoder dcbd_decoder_i (.mclk(mclk), .rst_b(rst_b), .host_byte(host_byte), .host_valid(host_valid),
    .host_ready(host_ready), .cmd(cmd), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .invalid_cmd(invalid_cmd), .err_code(err_code), .drive_char(drive_char), .char_valid(char_valid));

  dcbd_host_model dcbd_host_model_i (.mclk(mclk), .host_ready(host_ready), .host_byte(host_byte),
    .host_valid(host_valid), .hang(hang));

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic check(input string what, input logic [79:0] seen, input logic [79:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // The previous operation is retired late, so the first byte meets a refusal.
  task automatic issue(input logic [47:0] blk);
    int n;
    @(posedge mclk);
    fork
      begin
        for (n = 5; n >= 0; n--) begin
          dcbd_host_model_i.send(blk[n*8 +: 8]);
        end
      end
      begin
        repeat (2) @(posedge mclk);
        cmd_ready <= 1'b1;
        @(posedge mclk);
        cmd_ready <= 1'b0;
      end
    join
    dcbd_host_model_i.idle();
  endtask

  task automatic wait_cmd();
    int n;
    @(negedge mclk);
    for (n = 0; n < 20 && cmd_valid !== 1'b1; n++) begin
      @(negedge mclk);
    end
    if (cmd_valid !== 1'b1 || hang !== 1'b0) begin
      err_count++;
      final_report();
    end
  endtask

  task automatic run(input logic [47:0] blk);
    issue(blk);
    if (blk[47:40] == 8'h0c) begin
      @(negedge mclk);
      check("early issue", cmd_valid, 1'b0);
      @(posedge mclk);
      dcbd_host_model_i.send_char(CHR);
      dcbd_host_model_i.idle();
    end
    wait_cmd();
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    rst_b = 1'b0;
    cmd_ready = 1'b0;
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    @(negedge mclk);
    check("ready after reset", host_ready, 1'b1);
    check("valid after reset", {cmd_valid, char_valid}, 2'b00);
    for (i = 0; i < 19; i++) begin
      run({good_ops[i], 40'h25_95_34_10_05});
      check("op", cmd.op, 20'h00001 << (i + 1));
      check("no error", {invalid_cmd, err_code}, 7'h00);
    end
    check("characteristics", {char_valid, drive_char}, {1'b1, CHR});
    for (i = 0; i < 6; i++) begin
      run({bad_ops[i], 40'h25_95_34_10_05});
      check("unused op", {invalid_cmd, err_code, cmd.op},
            {1'b1, dcbd_pkg::ERR_INVALID, dcbd_pkg::DCBD_OP_NONE});
    end
    run(48'h08_25_95_34_07_05);
    check("read address", {cmd.drive, cmd.head, cmd.cylinder, cmd.sector, cmd.count},
          {1'b1, 5'h05, 10'h234, 6'h15, 8'h07});
    check("read control", {cmd.no_retry, cmd.no_reread, cmd.step, cmd.retries},
          {2'b00, 3'h5, dcbd_pkg::AUTO_RETRIES});
    run(48'h0a_25_95_34_03_86);
    check("write", {cmd.count, cmd.no_retry, cmd.step, cmd.data_bytes},
          {8'h03, 1'b1, 3'h6, dcbd_pkg::SECTOR_BYTES});
    run(48'h0b_25_95_34_ff_05);
    check("seek", {cmd.head, cmd.cylinder, cmd.count}, {5'h05, 10'h234, 8'h00});
    run(48'h06_25_40_34_10_05);
    check("format track", {cmd.cylinder, cmd.interleave}, {10'h134, 5'h10});
    run(48'h00_20_ff_ff_ff_ff);
    check("test ready", {cmd.op, cmd.drive}, {dcbd_pkg::DCBD_OP_TEST, 1'b1});
    run(48'he5_25_95_34_02_05);
    check("long read", {cmd.data_bytes, cmd.ecc_bytes}, {dcbd_pkg::SECTOR_BYTES, dcbd_pkg::ECC_BYTES});
    run(48'he6_25_95_34_02_05);
    check("long write", {cmd.op, cmd.data_bytes, cmd.ecc_bytes},
          {dcbd_pkg::DCBD_OP_WR_LONG, dcbd_pkg::SECTOR_BYTES, dcbd_pkg::ECC_BYTES});
    run(48'h05_25_c0_34_04_45);
    check("verify", {cmd.count, cmd.no_reread}, {8'h04, 1'b1});
    final_report();
  end
endmodule
